//--- rtl/epi_top.sv
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module epi_top #(
	parameter int BANK_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [epi_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [epi_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] dedicated_irq_pins,
	input wire logic [2*BANK_W-1:0] pin_change_inputs,
	input wire logic core_global_ie,
	input wire logic core_handler_ack,
	output logic irq,
	output logic [15:0] irq_vector,
	output logic wake_req
);
	import epi_pkg::*;

	typedef struct packed {
		logic aw_have;
		logic [ADDR_W-1:0] awaddr;
		logic w_have;
		logic [7:0] wdata;
		logic wlane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [SENSE_USED_W-1:0] sense;
		logic [NUM_SRC-1:0] enable;
		logic [NUM_SRC-1:0] flags;
		logic [BANK_W-1:0] lower_change_mask;
		logic [BANK_W-1:0] upper_change_mask;
		logic [1:0] ded_prev;
		logic irq;
		logic [15:0] vector;
	} epi_state_s;

	epi_state_s st_reg;
	epi_state_s st_next;

	logic [1:0] ded_sync;
	logic [2*BANK_W-1:0] pc_sync;
	logic lower_evt;
	logic upper_evt;
	logic lower_async;
	logic upper_async;

	// pad inputs are sampled whatever the pin direction
	epi_sync #(.W(2)) u_ded_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pins_async(dedicated_irq_pins),
		.pins_sync(ded_sync)
	);

	epi_sync #(.W(2*BANK_W)) u_pc_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pins_async(pin_change_inputs),
		.pins_sync(pc_sync)
	);

	epi_bank #(.W(BANK_W)) u_lower (
		.aclk(aclk),
		.aresetn(aresetn),
		.lines_sync(pc_sync[BANK_W-1:0]),
		.lines_async(pin_change_inputs[BANK_W-1:0]),
		.mask(st_reg.lower_change_mask),
		.change_event(lower_evt),
		.change_async(lower_async)
	);

	epi_bank #(.W(BANK_W)) u_upper (
		.aclk(aclk),
		.aresetn(aresetn),
		.lines_sync(pc_sync[2*BANK_W-1:BANK_W]),
		.lines_async(pin_change_inputs[2*BANK_W-1:BANK_W]),
		.mask(st_reg.upper_change_mask),
		.change_event(upper_evt),
		.change_async(upper_async)
	);

	function automatic logic [1:0] sense_of(
		input logic [SENSE_USED_W-1:0] s,
		input int idx
	);
		sense_of = s[idx*SENSE_FLD_W +: SENSE_FLD_W];
	endfunction

	function automatic logic [31:0] read_mux(
		input epi_state_s s,
		input logic [ADDR_W-1:0] a,
		input logic [1:0] ds,
		input logic [2*BANK_W-1:0] ps
	);
		read_mux = 32'h0000_0000;
		case (a)
			OFS_SENSE: read_mux[SENSE_USED_W-1:0] = s.sense;
			OFS_ENABLE: read_mux[NUM_SRC-1:0] = s.enable;
			OFS_FLAGS: read_mux[NUM_SRC-1:0] = s.flags;
			OFS_LOWER_MASK: read_mux[BANK_W-1:0] = s.lower_change_mask;
			OFS_UPPER_MASK: read_mux[BANK_W-1:0] = s.upper_change_mask;
			OFS_PIN_STATE: begin
				read_mux[2*BANK_W-1:0] = ps;
				read_mux[2*BANK_W +: 2] = ds;
			end
			OFS_VECTOR: read_mux[15:0] = s.vector;
			default: read_mux = 32'h0000_0000;
		endcase
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		case (a)
			OFS_SENSE, OFS_ENABLE, OFS_FLAGS, OFS_CLEAR,
			OFS_LOWER_MASK, OFS_UPPER_MASK, OFS_PIN_STATE,
			OFS_VECTOR: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction

	logic [1:0] level_req;
	logic [1:0] level_mode;
	logic [1:0] ded_set;
	logic [NUM_SRC-1:0] src_set;
	logic [NUM_SRC-1:0] src_clr;
	logic [NUM_SRC-1:0] pend;
	logic [NUM_SRC-1:0] pend_first;
	logic [1:0] code;
	logic do_write;
	logic was_rise;
	logic was_fall;

	always_comb begin
		st_next = st_reg;
		level_req = 2'b00;
		level_mode = 2'b00;
		ded_set = 2'b00;
		src_clr = '0;
		pend_first = '0;
		code = SENSE_LOW;
		was_rise = 1'b0;
		was_fall = 1'b0;

		// edges seen only by the clocked sampled path
		st_next.ded_prev = ded_sync;
		for (int i = 0; i < 2; i++) begin
			code = sense_of(st_reg.sense, i);
			was_rise = ~st_reg.ded_prev[i] & ded_sync[i];
			was_fall = st_reg.ded_prev[i] & ~ded_sync[i];
			case (code)
				SENSE_LOW: begin
					level_mode[i] = 1'b1;
					level_req[i] = ~ded_sync[i];
				end
				SENSE_ANY: ded_set[i] = was_rise | was_fall;
				SENSE_FALL: ded_set[i] = was_fall;
				SENSE_RISE: ded_set[i] = was_rise;
				default: ded_set[i] = 1'b0;
			endcase
		end
		// bank events already gated by the masks
		src_set = {upper_evt, lower_evt, ded_set};

		// own enable, then global enable below
		pend = st_reg.enable & (st_reg.flags | {2'b00, level_req});
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (pend[i]) begin
				pend_first = '0;
				pend_first[i] = 1'b1;
			end
		end

		// AXI write channels, taken in either order
		do_write = st_reg.aw_have & st_reg.w_have & ~st_reg.bvalid;
		if (s_axi_awvalid && s_axi_awready) begin
			st_next.aw_have = 1'b1;
			st_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_next.w_have = 1'b1;
			st_next.wdata = s_axi_wdata[7:0];
			st_next.wlane0 = s_axi_wstrb[0];
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end
		if (do_write) begin
			st_next.aw_have = 1'b0;
			st_next.w_have = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = mapped(st_reg.awaddr) ? RESP_OKAY : RESP_SLVERR;
			if (st_reg.wlane0) begin
				case (st_reg.awaddr)
					OFS_SENSE: st_next.sense = st_reg.wdata[SENSE_USED_W-1:0];
					OFS_ENABLE: st_next.enable = st_reg.wdata[NUM_SRC-1:0];
					OFS_CLEAR: src_clr = st_reg.wdata[NUM_SRC-1:0];
					OFS_LOWER_MASK: st_next.lower_change_mask = st_reg.wdata;
					OFS_UPPER_MASK: st_next.upper_change_mask = st_reg.wdata;
					default: src_clr = '0;
				endcase
			end
		end

		// handler entry clears the vectored flag
		if (core_handler_ack) begin
			src_clr = src_clr | pend_first;
		end
		st_next.flags = (st_reg.flags & ~src_clr) | src_set;
		// level mode keeps the dedicated flag clear
		st_next.flags[1:0] = st_next.flags[1:0] & ~level_mode;

		st_next.irq = core_global_ie & (|pend);
		// vector of highest priority pending source
		case (pend_first)
			4'h1: st_next.vector = VEC_PIN0;
			4'h2: st_next.vector = VEC_PIN1;
			4'h4: st_next.vector = VEC_LOWER;
			4'h8: st_next.vector = VEC_UPPER;
			default: st_next.vector = VEC_RESET;
		endcase

		// AXI read channel
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			st_next.rvalid = 1'b1;
			st_next.rdata = read_mux(st_reg, s_axi_araddr, ded_sync, pc_sync);
			st_next.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
			st_reg.sense <= RST_SENSE;
			st_reg.enable <= RST_ENABLE;
			st_reg.flags <= RST_FLAGS;
			st_reg.lower_change_mask <= RST_MASK;
			st_reg.upper_change_mask <= RST_MASK;
			st_reg.vector <= VEC_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	logic [1:0] wake_level;
	always_comb begin
		wake_level = 2'b00;
		for (int i = 0; i < 2; i++) begin
			// raw pin low, no clock needed
			wake_level[i] = st_reg.enable[i] & ~dedicated_irq_pins[i] &
				(sense_of(st_reg.sense, i) == SENSE_LOW);
		end
	end

	// wake from raw dedicated pin low levels or raw bank pin changes against held values
	assign wake_req = (|wake_level) |
		(st_reg.enable[SRC_LOWER] & lower_async) |
		(st_reg.enable[SRC_UPPER] & upper_async);

	assign s_axi_awready = ~st_reg.aw_have & ~st_reg.bvalid;
	assign s_axi_wready = ~st_reg.w_have & ~st_reg.bvalid;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = ~st_reg.rvalid;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign irq = st_reg.irq;
	assign irq_vector = st_reg.vector;
endmodule
`default_nettype wire

//--- rtl/epi_pkg.sv
package epi_pkg;

	localparam int ADDR_W = 8;
	localparam int NUM_SRC = 4;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_SENSE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CLEAR = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_LOWER_MASK = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_UPPER_MASK = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_PIN_STATE = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_VECTOR = 8'h1C;

	// Reset values
	localparam logic [3:0] RST_SENSE = 4'h0;
	localparam logic [3:0] RST_ENABLE = 4'h0;
	localparam logic [3:0] RST_FLAGS = 4'h0;
	localparam logic [7:0] RST_MASK = 8'h00;

	// Bit positions of the source layout (flags, enable, clear)
	localparam int SRC_PIN0 = 0;
	localparam int SRC_PIN1 = 1;
	localparam int SRC_LOWER = 2;
	localparam int SRC_UPPER = 3;

	// Sense control field width and used width of the sense register
	localparam int SENSE_FLD_W = 2;
	localparam int SENSE_USED_W = 4;

	// Sense codes
	localparam logic [1:0] SENSE_LOW = 2'h0;
	localparam logic [1:0] SENSE_ANY = 2'h1;
	localparam logic [1:0] SENSE_FALL = 2'h2;
	localparam logic [1:0] SENSE_RISE = 2'h3;

	// Program word addresses of the handlers
	localparam logic [15:0] VEC_RESET = 16'h0000;
	localparam logic [15:0] VEC_PIN0 = 16'h0002;
	localparam logic [15:0] VEC_PIN1 = 16'h0004;
	localparam logic [15:0] VEC_LOWER = 16'h0006;
	localparam logic [15:0] VEC_UPPER = 16'h0008;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- rtl/epi_sync.sv
`timescale 1ns/1ps
`default_nettype none
module epi_sync #(
	parameter int W = 2
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] pins_async,
	output logic [W-1:0] pins_sync
);
	import epi_pkg::*;

	typedef struct packed {
		logic [W-1:0] ff1;
		logic [W-1:0] ff2;
		logic [W-1:0] ff3;
		logic [W-1:0] stable;
	} epi_sync_s;

	epi_sync_s sync_reg;
	epi_sync_s sync_next;

	always_comb begin
		sync_next = sync_reg;
		sync_next.ff1 = pins_async;
		sync_next.ff2 = sync_reg.ff1;
		sync_next.ff3 = sync_reg.ff2;
		// A bit moves only once the second and third stages agree
		for (int i = 0; i < W; i++) begin
			if (sync_reg.ff2[i] == sync_reg.ff3[i]) begin
				sync_next.stable[i] = sync_reg.ff3[i];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign pins_sync = sync_reg.stable;
endmodule
`default_nettype wire

//--- rtl/epi_bank.sv
`timescale 1ns/1ps
`default_nettype none
module epi_bank #(
	parameter int W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] lines_sync,
	input wire logic [W-1:0] lines_async,
	input wire logic [W-1:0] mask,
	output logic change_event,
	output logic change_async
);
	import epi_pkg::*;

	typedef struct packed {
		logic [W-1:0] seen;
	} epi_bank_s;

	epi_bank_s bank_reg;
	epi_bank_s bank_next;

	always_comb begin
		bank_next = bank_reg;
		bank_next.seen = lines_sync;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bank_reg <= '0;
		end else begin
			bank_reg <= bank_next;
		end
	end

	assign change_event = |(mask & (lines_sync ^ bank_reg.seen));
	assign change_async = |(mask & (lines_async ^ bank_reg.seen));
endmodule
`default_nettype wire

//--- verif/epi_pin_src.sv
`timescale 1ns/1ps
`default_nettype none
module epi_pin_src (
	input wire logic [1:0] ded_want,
	input wire logic [15:0] pc_want,
	output wire logic [1:0] ded_pins,
	output wire logic [15:0] pc_pins
);
	// sources drive and hold levels
	// Edges land off the clock edge, like a real outside source
	assign #3 ded_pins = ded_want;
	assign #3 pc_pins = pc_want;
endmodule
`default_nettype wire

//--- verif/epi_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module epi_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [epi_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic core_global_ie,
	input wire logic irq,
	input wire logic [15:0] irq_vector
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_gie_gates_irq: assert property (!core_global_ie |=> !irq)
		else $error("irq without global enable");
	a_irq_has_vec: assert property (irq |-> irq_vector != 16'h0000)
		else $error("irq with empty vector");
	a_vec_legal: assert property (irq_vector inside {16'h0000, 16'h0002,
		16'h0004, 16'h0006, 16'h0008})
		else $error("vector off the table");
	a_sense_top_zero: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == 8'h00 |=> s_axi_rdata[31:4] == 28'h0)
		else $error("sense upper bits not zero");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid)
		else $error("read answer late");
endmodule
bind epi_top epi_chk chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .core_global_ie, .irq, .irq_vector);
`default_nettype wire

//--- verif/external_pin_interrupt_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
module external_pin_interrupt_unit_test;
	import epi_pkg::*;
	logic aclk = 0;
	logic aresetn = 0;
	logic [7:0] awaddr = 0, araddr = 0, msk;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, irq, wake_req;
	logic [31:0] wdata = 0, rdata;
	logic [1:0] bresp, rresp, ded;
	logic [1:0] ded_want = 2'h3;
	logic [15:0] pc_want = 16'h0000, pc, vec;
	logic gie = 0, ack = 0;
	logic [33:0] exp_q[$];
	logic [33:0] exp;
	int err_total = 0, compares = 0, cyc = 0, j, k;

	epi_pin_src src (.ded_want(ded_want), .pc_want(pc_want),
		.ded_pins(ded), .pc_pins(pc));
	epi_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.dedicated_irq_pins(ded), .pin_change_inputs(pc),
		.core_global_ie(gie), .core_handler_ack(ack), .irq(irq),
		.irq_vector(vec), .wake_req(wake_req));

	always #4 aclk = ~aclk;

	task close_out();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			close_out();
		end
	end

	// Scoreboard: oldest noted answer against each bus response
	always @(posedge aclk) begin
		if ((bvalid && bready) || (rvalid && rready)) begin
			exp = exp_q.pop_front();
			compares++;
			if (exp !== (bvalid ? {bresp, 32'h0} : {rresp, rdata})) begin
				err_total++;
				$display("[ERR] %0t bus answer, expected %h", $time, exp);
			end
		end
	end

	task chk(input logic got, input logic want);
		compares++;
		if (got !== want) begin
			err_total++;
			$display("[ERR] %0t pin level %b, expected %b", $time, got, want);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Response ready is sometimes late, so held answers get exercised
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic done;
		done = 1'b0;
		exp_q.push_back({r, 32'h0});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'($urandom_range(1));
		@(posedge aclk);
		while (!done) begin
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				bready <= 1'b0;
				done = 1'b1;
			end else if (bvalid) begin
				bready <= 1'b1;
			end
			@(posedge aclk);
		end
	endtask

	task rd(input logic [7:0] a, input logic [33:0] e);
		logic done;
		done = 1'b0;
		exp_q.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'($urandom_range(1));
		@(posedge aclk);
		while (!done) begin
			if (arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				rready <= 1'b0;
				done = 1'b1;
			end else if (rvalid) begin
				rready <= 1'b1;
			end
			@(posedge aclk);
		end
	endtask

	initial begin
		void'($urandom(32'h73f87d14));
		tick(2);
		aresetn <= 1'b1;
		for (int i = 0; i < 6; i++) rd(8'(4 * i), {RESP_OKAY, 32'h0});
		wr(OFS_SENSE, 32'hFF, RESP_OKAY);
		rd(OFS_SENSE, {RESP_OKAY, 32'h0F});
		wr(8'h20, 32'h1, RESP_SLVERR);
		rd(8'h20, {RESP_SLVERR, 32'h0});
		wr(OFS_FLAGS, 32'hF, RESP_OKAY);
		// Each sense code against a rising then a falling edge on pin zero
		for (int m = 0; m < 4; m++) begin
			for (int f = 0; f < 2; f++) begin
				ded_want[0] <= f[0];
				wr(OFS_SENSE, 32'(m), RESP_OKAY);
				tick(8);
				wr(OFS_CLEAR, 32'hF, RESP_OKAY);
				ded_want[0] <= !f[0];
				tick(8);
				rd(OFS_FLAGS, {RESP_OKAY, 31'h0, 1'((m == 1) || (m == 2 && f == 1)
					|| (m == 3 && f == 0))});
			end
		end
		wr(OFS_SENSE, 32'h0, RESP_OKAY);
		wr(OFS_ENABLE, 32'h1, RESP_OKAY);
		gie <= 1'b1;
		tick(8);
		chk(irq, 1'b1);
		rd(OFS_VECTOR, {RESP_OKAY, 16'h0, VEC_PIN0});
		rd(OFS_FLAGS, {RESP_OKAY, 32'h0});
		gie <= 1'b0;
		tick(3);
		chk(irq, 1'b0);
		ded_want[0] <= 1'b1;
		gie <= 1'b1;
		tick(8);
		ded_want[0] <= 1'b0;
		@(posedge aclk);
		ded_want[0] <= 1'b1;
		chk(wake_req, 1'b1);
		repeat (8) begin
			@(posedge aclk);
			chk(irq, 1'b0);
		end
		gie <= 1'b0;
		wr(OFS_ENABLE, 32'hC, RESP_OKAY);
		for (int b = 0; b < 2; b++) begin
			j = $urandom_range(7);
			k = (j + 1) % 8;
			msk = (8'($urandom()) | 8'(1 << j)) & ~8'(1 << k);
			wr(b ? OFS_UPPER_MASK : OFS_LOWER_MASK, {24'h0, msk}, RESP_OKAY);
			wr(OFS_CLEAR, 32'hF, RESP_OKAY);
			pc_want[8 * b + k] <= ~pc_want[8 * b + k];
			@(posedge aclk);
			chk(wake_req, 1'b0);
			tick(8);
			rd(OFS_FLAGS, {RESP_OKAY, 32'h0});
			pc_want[8 * b + j] <= ~pc_want[8 * b + j];
			@(posedge aclk);
			chk(wake_req, 1'b1);
			tick(8);
			rd(OFS_FLAGS, {RESP_OKAY, 32'(4 << b)});
		end
		ded_want[1] <= 1'b0;
		wr(OFS_SENSE, 32'hC, RESP_OKAY);
		wr(OFS_ENABLE, 32'h2, RESP_OKAY);
		tick(8);
		wr(OFS_CLEAR, 32'hF, RESP_OKAY);
		ded_want[1] <= 1'b1;
		gie <= 1'b1;
		tick(8);
		chk(irq, 1'b1);
		rd(OFS_VECTOR, {RESP_OKAY, 16'h0, VEC_PIN1});
		ack <= 1'b1;
		@(posedge aclk);
		ack <= 1'b0;
		tick(3);
		chk(irq, 1'b0);
		rd(OFS_FLAGS, {RESP_OKAY, 32'h0});
		rd(OFS_PIN_STATE, {RESP_OKAY, 14'h0, ded_want, pc_want});
		close_out();
	end
endmodule
`default_nettype wire
